// file: hdl/return_stack.sv
// Return address stack with push, pop, pointer and top-entry registers
module return_stack (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input return_stack_pkg::stack_req_s core_req,
  output logic [20:0] pop_pc,
  output logic pop_valid,
  output logic stack_reset_req
);
  localparam int PC_W = return_stack_pkg::PC_W;
  localparam int PTR_W = return_stack_pkg::PTR_W;
  // Pointer value at which the next push is the last one that fits
  localparam logic [PTR_W-1:0] PTR_LAST = return_stack_pkg::PTR_MAX - 5'h01;

  logic [PTR_W-1:0] ptr_q;
  logic full_q;
  logic unf_q;
  logic ovf_rst_en_q;
  logic [PC_W-1:0] top_q;
  logic [PC_W-1:0] ram_rdata;
  logic ram_we;
  logic [PTR_W-1:0] ram_waddr;
  logic [PTR_W-1:0] ram_raddr;
  logic [PC_W-1:0] ram_wdata;
  logic reload_q;
  logic [PTR_W-1:0] ptr_d;
  logic push;
  logic pop;
  logic sw_wr;
  logic apb_acc;
  logic map_hit;
  logic wr_ptr;
  logic wr_low;
  logic wr_high;
  logic wr_upper;
  logic at_max;
  logic push_full;
  logic push_last;
  logic [PC_W-1:0] top_cur;

  // ==========================================================
  // Decode
  assign push = core_req.push && !core_req.pop;
  assign pop = core_req.pop && !core_req.push;
  assign apb_acc = psel && penable;
  assign sw_wr = apb_acc && pwrite;
  assign map_hit = paddr == return_stack_pkg::ADDR_PTR ||
    paddr == return_stack_pkg::ADDR_TOP_LOW ||
    paddr == return_stack_pkg::ADDR_TOP_HIGH ||
    paddr == return_stack_pkg::ADDR_TOP_UPPER ||
    paddr == return_stack_pkg::ADDR_CTRL;
  assign wr_ptr = sw_wr && paddr == return_stack_pkg::ADDR_PTR;
  assign wr_low = sw_wr && paddr == return_stack_pkg::ADDR_TOP_LOW;
  assign wr_high = sw_wr && paddr == return_stack_pkg::ADDR_TOP_HIGH;
  assign wr_upper = sw_wr && paddr == return_stack_pkg::ADDR_TOP_UPPER;
  assign at_max = ptr_q == return_stack_pkg::PTR_MAX;
  assign push_full = push && at_max;
  assign push_last = push && !at_max &&
    ptr_q == return_stack_pkg::PTR_MAX - 5'h01;

  // ==========================================================
  // Pointer next value
  always_comb begin
    ptr_d = ptr_q;
    if (push && !at_max) begin
      ptr_d = ptr_q + 5'h01;
    end else if (pop && ptr_q != return_stack_pkg::PTR_RESET) begin
      ptr_d = ptr_q - 5'h01;
    end else if (wr_ptr && !push && !pop) begin
      ptr_d = pwdata[PTR_W-1:0];
    end
    if (push_last && ovf_rst_en_q) begin
      ptr_d = return_stack_pkg::PTR_RESET;
    end
  end

  // Stack pointer register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ptr_q <= return_stack_pkg::PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Sticky flags; hardware set wins over software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
    end else begin
      if (push_last || push_full) begin
        full_q <= 1'b1;
      end else if (wr_ptr && !pwdata[return_stack_pkg::FULL_BIT]) begin
        full_q <= 1'b0;
      end
      if (pop && ptr_q == return_stack_pkg::PTR_RESET) begin
        unf_q <= 1'b1;
      end else if (wr_ptr && !pwdata[return_stack_pkg::UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  // Overflow reset enable control
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ovf_rst_en_q <= return_stack_pkg::CTRL_RESET;
    end else if (sw_wr && paddr == return_stack_pkg::ADDR_CTRL) begin
      ovf_rst_en_q <= pwdata[return_stack_pkg::OVF_RST_BIT];
    end
  end

  // ==========================================================
  // Entry memory write: push or software byte write of top entry
  always_comb begin
    ram_we = 1'b0;
    ram_waddr = ptr_d;
    ram_wdata = top_cur;
    if (push && !at_max) begin
      ram_we = 1'b1;
      ram_wdata = ovf_rst_en_q && push_last ?
        core_req.pc + return_stack_pkg::PC_STEP : core_req.pc;
      ram_waddr = ptr_q + 5'h01;
    end else if (wr_low || wr_high || wr_upper) begin
      ram_we = 1'b1;
      ram_waddr = ptr_q;
      if (wr_low) ram_wdata[7:0] = pwdata[7:0];
      if (wr_high) ram_wdata[15:8] = pwdata[7:0];
      if (wr_upper) ram_wdata[20:16] = pwdata[4:0];
    end
  end
  assign ram_raddr = ptr_d;
  // Current top entry; memory data while the mirror is still reloading
  assign top_cur = reload_q ? ram_rdata : top_q;

  stack_ram u_ram (
    .sys_clk(sys_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata(ram_rdata)
  );

  // Top entry mirror; write forwarding covers same-cycle read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      top_q <= return_stack_pkg::PC_ZERO;
      reload_q <= 1'b0;
    end else begin
      reload_q <= 1'b0;
      if (ram_we && ram_waddr == ptr_d) begin
        top_q <= ram_wdata;
      end else if (ptr_d != ptr_q) begin
        reload_q <= 1'b1;
      end else if (reload_q) begin
        top_q <= ram_rdata;
      end
    end
  end

  // ==========================================================
  // Pop answer and device reset request to the core
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pop_pc <= return_stack_pkg::PC_ZERO;
      pop_valid <= 1'b0;
      stack_reset_req <= 1'b0;
    end else begin
      pop_valid <= pop;
      if (pop) begin
        pop_pc <= ptr_q == return_stack_pkg::PTR_RESET ?
          return_stack_pkg::PC_ZERO : top_cur;
      end
      stack_reset_req <= push_last && ovf_rst_en_q;
    end
  end

  // ==========================================================
  // APB slave: no wait state, error on unmapped address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          return_stack_pkg::ADDR_PTR:
            prdata[7:0] <= {full_q, unf_q, 1'b0, ptr_q};
          return_stack_pkg::ADDR_TOP_LOW: prdata[7:0] <= top_cur[7:0];
          return_stack_pkg::ADDR_TOP_HIGH: prdata[7:0] <= top_cur[15:8];
          return_stack_pkg::ADDR_TOP_UPPER: prdata[4:0] <= top_cur[20:16];
          return_stack_pkg::ADDR_CTRL: prdata[0] <= ovf_rst_en_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  chk_push_advances: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    push && ptr_q < PTR_LAST |=> ptr_q == $past(ptr_q) + 5'h01)
    else $error("push did not advance pointer");
  chk_pop_retreats: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop && ptr_q != return_stack_pkg::PTR_RESET |=>
    ptr_q == $past(ptr_q) - 5'h01)
    else $error("pop did not retreat pointer");
  chk_push_stores_pc: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    push && ptr_q < PTR_LAST |=> top_q == $past(core_req.pc))
    else $error("pushed pc not on top");
  chk_full_sets: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    push && ptr_q == PTR_LAST |=> full_q)
    else $error("full flag not set");
  chk_unf_sets: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pop && ptr_q == return_stack_pkg::PTR_RESET |=> unf_q &&
    ptr_q == return_stack_pkg::PTR_RESET &&
    pop_pc == return_stack_pkg::PC_ZERO)
    else $error("underflow handling wrong");
  chk_unf_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    unf_q && !wr_ptr |=> unf_q)
    else $error("underflow flag dropped");
  chk_hold_at_max: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    push && at_max |=> ptr_q == return_stack_pkg::PTR_MAX)
    else $error("pointer moved past max");
  chk_ovf_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    push && ptr_q == PTR_LAST && ovf_rst_en_q |=> stack_reset_req &&
    ptr_q == return_stack_pkg::PTR_RESET && full_q)
    else $error("overflow reset not taken");
  chk_bit5_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pready && !pwrite && paddr == return_stack_pkg::ADDR_PTR |->
    prdata[31:8] == 24'h00_0000 && prdata[5] == 1'b0 &&
    prdata[4:0] == $past(ptr_q))
    else $error("pointer readback wrong");
endmodule : return_stack

// file: hdl/return_stack_pkg.sv
// Package: register map, field layout and widths of the return stack
package return_stack_pkg;
  // ==========================================================
  // Widths
  localparam int PC_W = 21;
  localparam int PTR_W = 5;
  localparam int DEPTH = 32;
  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_PTR = 12'h000;
  localparam logic [11:0] ADDR_TOP_LOW = 12'h004;
  localparam logic [11:0] ADDR_TOP_HIGH = 12'h008;
  localparam logic [11:0] ADDR_TOP_UPPER = 12'h00C;
  localparam logic [11:0] ADDR_CTRL = 12'h010;
  // ==========================================================
  // Field positions and values
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int OVF_RST_BIT = 0;
  localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
  localparam logic [PTR_W-1:0] PTR_MAX = 5'h1F;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] PC_ZERO = 21'h00_0000;
  localparam logic CTRL_RESET = 1'b1;
  // Core request carrier
  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_W-1:0] pc;
  } stack_req_s;
endpackage : return_stack_pkg

// file: hdl/stack_ram.sv
// Memory: 32 return address entries, registered read
module stack_ram (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [20:0] wdata,
  input wire logic [4:0] raddr,
  output logic [20:0] rdata
);
  logic [20:0] mem [return_stack_pkg::DEPTH];

  // Write port
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk) begin
    rdata <= mem[raddr];
  end
endmodule : stack_ram

// file: tb/core_seq.sv
// Core sequencer model: issues push and pop requests
module core_seq (
  input wire logic sys_clk,
  output return_stack_pkg::stack_req_s core_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial core_req = '0;
  // One request for a cycle, then a random quiet gap of 1 to 3 cycles
  task automatic issue(input logic psh, input logic [20:0] pc);
    @(posedge sys_clk);
    core_req <= '{push: psh, pop: ~psh, pc: pc};
    @(posedge sys_clk);
    core_req <= '0;
    repeat (1 + $urandom % 3) @(posedge sys_clk);
  endtask : issue
endmodule : core_seq

// file: tb/tb.sv
// Self-checking bench of the return stack
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  return_stack_pkg::stack_req_s core_req;
  logic [20:0] pop_pc;
  logic pop_valid;
  logic stack_reset_req;
  int fails = 0;
  int num_checks = 0;
  int resets = 0;
  logic [33:0] rd_q[$];
  logic [20:0] pop_q[$];
  logic [33:0] e;
  logic [20:0] pa, pb, pc;
  // ==========================================================
  // Design and core model
  return_stack return_stack_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_req(core_req),
    .pop_pc(pop_pc), .pop_valid(pop_valid),
    .stack_reset_req(stack_reset_req)
  );
  core_seq core_seq_inst (.sys_clk(sys_clk), .core_req(core_req));
  // Clock of 100 ns period
  always #50 sys_clk = ~sys_clk;
  // Compare one value against its expectation
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One bus transfer; the expected answer goes to the queue at setup
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [33:0] exp);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    rd_q.push_back(exp);
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0000_0000, {1'b1, x});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0_0000_0000);
  endtask : wr
  // Read the three top entry bytes
  task automatic top(input logic [20:0] v);
    rd(return_stack_pkg::ADDR_TOP_LOW, 33'(v[7:0]));
    rd(return_stack_pkg::ADDR_TOP_HIGH, 33'(v[15:8]));
    rd(return_stack_pkg::ADDR_TOP_UPPER, 33'(v[20:16]));
  endtask : top
  // ==========================================================
  // Scoreboard: each answer takes the oldest note off its queue
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = rd_q.pop_front();
      if (e[33]) check({1'b0, pslverr, prdata}, {1'b0, e[32:0]});
      else check(34'(pslverr), 34'(e[32]));
    end
    if (pop_valid === 1'b1) begin
      if (pop_q.size() > 0) check(34'(pop_pc), 34'(pop_q.pop_front()));
      else check(34'h1, 34'h0);
    end
    if (stack_reset_req === 1'b1) resets++;
  end
  // Main sequence
  initial begin
    void'($urandom(32'h0bc7));
    pa = 21'($urandom);
    pb = 21'($urandom);
    pc = 21'($urandom);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0000);
    rd(return_stack_pkg::ADDR_CTRL, 33'h0_0000_0001);
    apb(1'b0, 12'h014, 32'h0000_0000, 34'h3_0000_0000);
    apb(1'b1, 12'h018, 32'hFFFF_FFFF, 34'h1_0000_0000);
    core_seq_inst.issue(1'b1, pa);
    core_seq_inst.issue(1'b1, pb);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0002);
    top(pb);
    wr(return_stack_pkg::ADDR_TOP_LOW, 32'(pc[7:0]));
    wr(return_stack_pkg::ADDR_TOP_HIGH, 32'(pc[15:8]));
    wr(return_stack_pkg::ADDR_TOP_UPPER, 32'(pc[20:16]));
    top(pc);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0002);
    pop_q.push_back(pc);
    core_seq_inst.issue(1'b0, pb);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0001);
    top(pa);
    pop_q.push_back(pa);
    core_seq_inst.issue(1'b0, pc);
    pop_q.push_back(21'h00_0000);
    core_seq_inst.issue(1'b0, pa);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0040);
    wr(return_stack_pkg::ADDR_PTR, 32'h0000_006A);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_004A);
    wr(return_stack_pkg::ADDR_PTR, 32'h0000_0000);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0000);
    // Fill with overflow reset off, then push once more
    wr(return_stack_pkg::ADDR_CTRL, 32'h0000_0000);
    for (int i = 1; i <= 31; i++) core_seq_inst.issue(1'b1, 21'(i));
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_009F);
    core_seq_inst.issue(1'b1, pa);
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_009F);
    top(21'h00_001F);
    // Fill with overflow reset on
    wr(return_stack_pkg::ADDR_PTR, 32'h0000_0000);
    wr(return_stack_pkg::ADDR_CTRL, 32'h0000_0001);
    for (int i = 1; i <= 31; i++) core_seq_inst.issue(1'b1, 21'(i));
    rd(return_stack_pkg::ADDR_PTR, 33'h0_0000_0080);
    // Point at the last entry: it must hold the pushed value plus 2
    wr(return_stack_pkg::ADDR_PTR, 32'h0000_009F);
    top(21'h00_0021);
    check(34'(resets), 34'h1);
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (8000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
  // Print counts and verdict, then end the run
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
endmodule : tb
